// file: rtl/bas_defines.vh
// constants for the block address sequencer
`ifndef BAS_DEFINES_VH
`define BAS_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BAS_OFF_START   8'h00
`define BAS_OFF_STEP    8'h04
`define BAS_OFF_BSIZE   8'h08
`define BAS_OFF_BSTEP   8'h0c
`define BAS_OFF_BCOUNT  8'h10
`define BAS_OFF_MODE    8'h14
`define BAS_OFF_SDLY    8'h18
`define BAS_OFF_CTRL    8'h1c
`define BAS_OFF_STATUS  8'h20
`define BAS_OFF_XIDX    8'h24
`define BAS_OFF_XDATA   8'h28
// ----------------------------------------
// fields
// ----------------------------------------
`define BAS_MODE_M1     1
`define BAS_MODE_DS     2
`define BAS_MODE_OD_LO  3
`define BAS_SDLY_EN     5
`define BAS_XDATA_INC   6
`define BAS_XMAX        5'h17
`define BAS_NBITS       24
`define BAS_HBITS       12
`define BAS_NDLY        8
`define BAS_AHB_NONSEQ  2'h2
`endif

// file: rtl/bas_delay_mem.v
// delay line holding past lower-word values, read data registered
module bas_delay_mem #(
  parameter W = 12,
  parameter D = 8
) (
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         adv,
  input  wire [W-1:0] din,
  input  wire [2:0]   sel,
  output reg  [W-1:0] dout
);
  reg [W-1:0] mem [0:D-1];
  integer i;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < D; i = i + 1)
        mem[i] <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      if (adv)
      begin
        mem[0] <= din;
        for (i = 1; i < D; i = i + 1)
          mem[i] <= mem[i-1];
      end
      // sel 0 is current word, sel n is n clocks old
      dout <= (sel == 3'h0) ? din : mem[sel - 3'h1];
    end
  end
endmodule // bas_delay_mem

// file: rtl/bas_top.v
// block address sequencer: ahb-lite registers, sequencer, crosspoint, delay
`include "bas_defines.vh"
module bas_top (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        start_in,
  output reg  [23:0] addr_out,
  output reg         addr_valid,
  output reg         busy,
  output reg         block_done,
  output reg         seq_done
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg        rst_s1;
  reg        rst_n;
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [23:0] r_start;
  reg  [23:0] r_step;
  reg  [23:0] r_bsize;
  reg  [23:0] r_bstep;
  reg  [23:0] r_bcount;
  reg  [5:0]  r_mode;
  reg  [5:0]  r_sdly;
  reg  [4:0]  x_idx;
  reg  [4:0]  x_pend [0:23];
  reg  [4:0]  x_act  [0:23];
  reg  [5:0]  x_pend_hi;
  reg  [23:0] x_big_pend;
  reg  [23:0] x_big_act;
  reg         wr_ph;
  reg  [7:0]  wr_off;
  reg         go_pulse;
  wire        dual = r_mode[`BAS_MODE_DS];
  wire        acc  = hsel & hready & (htrans == `BAS_AHB_NONSEQ);
  integer     k;

  // state
  localparam S_IDLE = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_RUN  = 3'h4;
  reg  [2:0]  state;
  reg  [4:0]  dly_cnt;
  reg  [23:0] cur;
  reg  [23:0] bbase;
  reg  [23:0] in_cnt;
  reg  [23:0] blk_cnt;
  reg  [23:0] seq_out;
  reg         seq_val;
  reg         restart_req;

  wire        load_start = go_pulse | start_in;
  wire        xload = (load_start | restart_req) & (state == S_IDLE);

  // 12 or 24-bit wrapped add, halves independent in dual mode
  function [23:0] wadd;
    input [23:0] a;
    input [23:0] b;
    input        d;
    begin
      if (d)
        wadd = {a[23:12] + b[23:12], a[11:0] + b[11:0]};
      else
        wadd = a + b;
    end
  endfunction

  // one when a down count has reached its last item
  function is_last;
    input [23:0] c;
    begin
      is_last = (c <= 24'h000001);
    end
  endfunction

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_ph     <= 1'b0;
      wr_off    <= 8'h00;
      r_start   <= 24'h000000;
      r_step    <= 24'h000000;
      r_bsize   <= 24'h000000;
      r_bstep   <= 24'h000000;
      r_bcount  <= 24'h000000;
      r_mode    <= 6'h00;
      r_sdly    <= 6'h00;
      x_idx     <= 5'h00;
      go_pulse  <= 1'b0;
      x_big_pend <= 24'h000000;
      x_big_act  <= 24'h000000;
      for (k = 0; k < 24; k = k + 1)
      begin
        x_pend[k] <= k[4:0];
        x_act[k]  <= k[4:0];
      end
    end
    else
    begin
      go_pulse <= 1'b0;
      wr_ph    <= acc & hwrite;
      wr_off   <= haddr[7:0];
      if (xload)
      begin
        x_big_act <= x_big_pend;
        for (k = 0; k < 24; k = k + 1)
          x_act[k] <= x_pend[k];
      end
      if (acc & !hwrite)
      begin
        case (haddr[7:0])
          `BAS_OFF_START:  hrdata <= {8'h00, r_start};
          `BAS_OFF_STEP:   hrdata <= {8'h00, r_step};
          `BAS_OFF_BSIZE:  hrdata <= {8'h00, r_bsize};
          `BAS_OFF_BSTEP:  hrdata <= {8'h00, r_bstep};
          `BAS_OFF_BCOUNT: hrdata <= {8'h00, r_bcount};
          `BAS_OFF_MODE:   hrdata <= {26'h0000000, r_mode};
          `BAS_OFF_SDLY:   hrdata <= {26'h0000000, r_sdly};
          `BAS_OFF_STATUS: hrdata <= {29'h00000000, state};
          `BAS_OFF_XIDX:   hrdata <= {27'h0000000, x_idx};
          `BAS_OFF_XDATA:  hrdata <= {26'h0000000, x_big_pend[x_idx], x_pend[x_idx]};
          default:         hrdata <= 32'h00000000;
        endcase
      end
      if (wr_ph)
      begin
        case (wr_off)
          `BAS_OFF_START:  r_start  <= hwdata[23:0];
          `BAS_OFF_STEP:   r_step   <= hwdata[23:0];
          `BAS_OFF_BSIZE:  r_bsize  <= hwdata[23:0];
          `BAS_OFF_BSTEP:  r_bstep  <= hwdata[23:0];
          `BAS_OFF_BCOUNT: r_bcount <= hwdata[23:0];
          `BAS_OFF_MODE:   r_mode   <= hwdata[5:0];
          `BAS_OFF_SDLY:   r_sdly   <= hwdata[5:0];
          `BAS_OFF_CTRL:   go_pulse <= hwdata[0];
          `BAS_OFF_XIDX:   x_idx    <= hwdata[4:0];
          `BAS_OFF_XDATA:
          begin
            // index above 23 is ignored
            if (x_idx <= `BAS_XMAX)
            begin
              x_pend[x_idx]     <= hwdata[4:0];
              x_big_pend[x_idx] <= (hwdata[5:0] > {1'b0, `BAS_XMAX});
            end
            if (hwdata[`BAS_XDATA_INC])
              x_idx <= x_idx + 5'h01;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire        restart_ok = (r_mode[1:0] != 2'h0);
  wire        blk_end    = is_last(in_cnt);
  wire        seq_end    = blk_end & is_last(blk_cnt);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= S_IDLE;
      dly_cnt    <= 5'h00;
      cur        <= 24'h000000;
      bbase      <= 24'h000000;
      in_cnt     <= 24'h000000;
      blk_cnt    <= 24'h000000;
      seq_out    <= 24'h000000;
      seq_val    <= 1'b0;
      busy       <= 1'b0;
      block_done <= 1'b0;
      seq_done   <= 1'b0;
    end
    else
    begin
      seq_val    <= 1'b0;
      block_done <= 1'b0;
      seq_done   <= 1'b0;
      case (state)
        S_IDLE:
        begin
          busy <= 1'b0;
          if (load_start | restart_req)
          begin
            busy    <= 1'b1;
            cur     <= r_start;
            bbase   <= r_start;
            in_cnt  <= r_bsize;
            blk_cnt <= r_bcount;
            if (r_sdly[`BAS_SDLY_EN] && r_sdly[4:0] != 5'h00)
            begin
              dly_cnt <= r_sdly[4:0];
              state   <= S_WAIT;
            end
            else
              state <= S_RUN;
          end
        end
        S_WAIT:
        begin
          dly_cnt <= dly_cnt - 5'h01;
          if (dly_cnt == 5'h01)
            state <= S_RUN;
        end
        S_RUN:
        begin
          seq_out <= cur;
          seq_val <= 1'b1;
          if (seq_end)
          begin
            block_done <= 1'b1;
            seq_done   <= 1'b1;
            // continuous runs come back through idle, so restarts get the start delay too
            state <= S_IDLE;
          end
          else if (blk_end)
          begin
            block_done <= 1'b1;
            bbase   <= wadd(bbase, r_bstep, dual);
            cur     <= wadd(bbase, r_bstep, dual);
            in_cnt  <= r_bsize;
            blk_cnt <= blk_cnt - 24'h000001;
          end
          else
          begin
            cur    <= wadd(cur, r_step, dual);
            in_cnt <= in_cnt - 24'h000001;
          end
        end
        default: state <= S_IDLE;
      endcase
      // a start while running restarts the sequence unless mode is one-shot without restart
      if (load_start && restart_ok && state != S_IDLE)
        state <= S_IDLE;
    end
  end

  // one-cycle restart: end of a continuous run, or a start taken while running
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      restart_req <= 1'b0;
    else
      restart_req <= ((state == S_RUN) & seq_end & r_mode[`BAS_MODE_M1]) |
                     (load_start & restart_ok & (state != S_IDLE));
  end

  // ----------------------------------------
  // crosspoint and output delay
  // ----------------------------------------
  reg  [23:0] xout;
  integer     j;
  always @*
  begin
    xout = 24'h000000;
    for (j = 0; j < `BAS_NBITS; j = j + 1)
      if (!x_big_act[j] && x_act[j] <= `BAS_XMAX)
        xout[j] = seq_out[x_act[j]];
  end

  reg  [23:0] xreg;
  reg         xval;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xreg <= 24'h000000;
      xval <= 1'b0;
    end
    else
    begin
      xreg <= xout;
      xval <= seq_val;
    end
  end

  wire [11:0] lo_dly;
  bas_delay_mem #(
    .W (`BAS_HBITS),
    .D (`BAS_NDLY)
  ) u_dly (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .adv     (1'b1),
    .din     (xout[11:0]),
    .sel     (r_mode[5:`BAS_MODE_OD_LO]),
    .dout    (lo_dly)
  );

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_out   <= 24'h000000;
      addr_valid <= 1'b0;
    end
    else
    begin
      addr_out   <= {xreg[23:12], lo_dly};
      addr_valid <= xval;
    end
  end
endmodule // bas_top

// file: dv/bas_mem_model.sv
// memory bank model that logs every generated address
module bas_mem_model (
  input wire logic        clk_sys,
  input wire logic [23:0] addr,
  input wire logic        valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] log_q[$];
  // one word fetched per valid address; the log is never cleared, users keep a base index
  always @(posedge clk_sys)
    if (valid === 1'b1)
      log_q.push_back(addr);
endmodule // bas_mem_model

// file: dv/bas_top_properties.sv
// assertions on the sequencer's status outputs
module bas_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic addr_valid,
  input wire logic busy,
  input wire logic block_done,
  input wire logic seq_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // a delay of 31 plus the pipeline fits in 40
  sequence s_first;
    ##[1:40] addr_valid;
  endsequence
  sequence s_stop;
    ##[1:6] !busy;
  endsequence
  // continuous mode: a fresh address past the tail of the run just ended
  sequence s_again;
    ##[3:40] addr_valid;
  endsequence
  AST_LAST_IS_BLOCK_END: assert property (seq_done |-> block_done)
    else $error("sequence ended off a block end");
  AST_DONE_WHILE_RUN: assert property (block_done |-> $past(busy))
    else $error("block end while idle");
  AST_DONE_LEADS_VALID: assert property (block_done |-> ##2 addr_valid)
    else $error("block end without its address");
  AST_SEQ_STOPS: assert property (seq_done |-> s_stop or s_again)
    else $error("engine kept running after the end");
  AST_SDONE_PULSE: assert property (seq_done |=> !seq_done)
    else $error("sequence end longer than one cycle");
  AST_FIRST_ADDR: assert property ($rose(busy) |-> s_first)
    else $error("no address after start");
  AST_NO_EARLY: assert property ($rose(busy) |-> !addr_valid)
    else $error("address at the start cycle");
  AST_IDLE_SILENT: assert property (!busy [*4] |-> !addr_valid)
    else $error("address while idle");
endmodule // bas_props
bind bas_top bas_props u_props (.clk_sys(clk_sys), .rstn(rstn), .addr_valid(addr_valid),
  .busy(busy), .block_done(block_done), .seq_done(seq_done));

// file: dv/bas_top_tb.sv
// self-checking testbench for the block address sequencer
`include "bas_defines.vh"
module bas_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rstn, hsel, hwrite, start_in;
  logic        hreadyout, hresp, addr_valid, busy, block_done, seq_done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] addr_out;
  logic [5:0]  xm[24];
  int          mismatches, samples_checked;

  bas_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .start_in(start_in), .addr_out(addr_out), .addr_valid(addr_valid),
    .busy(busy), .block_done(block_done), .seq_done(seq_done));
  bas_mem_model u_mem (.clk_sys(clk_sys), .addr(addr_out), .valid(addr_valid));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task fail;
    mismatches++;
    report_and_stop;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  // bounded wait for hready at a rising edge
  task tick;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      fail;
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= `BAS_AHB_NONSEQ;
    tick;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    tick;
    rd = hrdata;
  endtask

  function logic [23:0] xp(input logic [23:0] v);
    for (int o = 0; o < 24; o++)
      xp[o] = (xm[o] > 6'h17) ? 1'b0 : v[xm[o]];
  endfunction

  task go(input logic [23:0] s, st, bs, bt, bc, output int b);
    int n;
    b = u_mem.log_q.size();
    bus(1, `BAS_OFF_START, s);
    bus(1, `BAS_OFF_STEP, st);
    bus(1, `BAS_OFF_BSIZE, bs);
    bus(1, `BAS_OFF_BSTEP, bt);
    bus(1, `BAS_OFF_BCOUNT, bc);
    bus(1, `BAS_OFF_CTRL, 32'h00000001);
    for (n = 0; n < 500 && !(busy === 1'b0 && u_mem.log_q.size() - b >= bs * bc); n++)
      @(posedge clk_sys);
    if (n >= 500)
      fail;
    repeat (8) @(posedge clk_sys);
    chk("count", bs * bc, u_mem.log_q.size() - b);
    chk("busy", 0, busy);
  endtask

  task run(input logic [23:0] s, st, bs, bt, bc);
    int b;
    go(s, st, bs, bt, bc, b);
    // sum wraps in 24 bits, as the engine's does
    for (int i = 0; i < bs * bc; i++)
      chk("addr", xp(s + (i / bs) * bt + (i % bs) * st), u_mem.log_q[b + i]);
  endtask

  task lat(output int n);
    start_in <= 1'b1;
    @(posedge clk_sys);
    start_in <= 1'b0;
    for (n = 0; n < 100 && addr_valid !== 1'b1; n++)
      @(posedge clk_sys);
    if (n >= 100)
      fail;
    repeat (40) @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    bus(1, 8'h40, 32'h0000003f);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, rd);
    bus(0, `BAS_OFF_MODE, 0);
    chk("mode", 0, rd);
    bus(0, `BAS_OFF_SDLY, 0);
    chk("sdly", 0, rd);
    bus(0, `BAS_OFF_STATUS, 0);
    chk("status", 1, rd);
    chk("hresp", 0, hresp);
  endtask

  task t_modes;
    int b, n;
    for (int m = 0; m < 2; m++)
    begin
      bus(1, `BAS_OFF_MODE, m);
      run(35, 1, 3, 16, 2);
    end
    // continuous: let it wrap at least once, then drop to one-shot so it stops at an end
    b = u_mem.log_q.size();
    bus(1, `BAS_OFF_MODE, 32'h00000002);
    bus(1, `BAS_OFF_CTRL, 32'h00000001);
    for (n = 0; n < 500 && u_mem.log_q.size() - b < 12; n++)
      @(posedge clk_sys);
    if (n >= 500)
      fail;
    bus(1, `BAS_OFF_MODE, 0);
    for (n = 0; n < 500 && busy !== 1'b0; n++)
      @(posedge clk_sys);
    if (n >= 500)
      fail;
    repeat (8) @(posedge clk_sys);
    chk("cont whole runs", 0, (u_mem.log_q.size() - b) % 6);
    for (int i = 0; i < 12; i++)
      chk("cont addr", 35 + (i % 6 / 3) * 16 + i % 3, u_mem.log_q[b + i]);
  endtask

  // a second start four cycles into a run: a restart in mode 01, none in mode 00
  task t_restart;
    int b, n;
    for (int m = 0; m < 2; m++)
    begin
      bus(1, `BAS_OFF_MODE, m);
      b = u_mem.log_q.size();
      start_in <= 1'b1;
      @(posedge clk_sys);
      start_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      start_in <= 1'b1;
      @(posedge clk_sys);
      start_in <= 1'b0;
      for (n = 0; n < 100 && busy !== 1'b0; n++)
        @(posedge clk_sys);
      if (n >= 100)
        fail;
      repeat (8) @(posedge clk_sys);
      chk("restart count", 6 + m * 4, u_mem.log_q.size() - b);
      for (int i = 0; i < 6; i++)
        chk("restart addr", 35 + (i / 3) * 16 + i % 3,
            u_mem.log_q[u_mem.log_q.size() - 6 + i]);
    end
    bus(1, `BAS_OFF_MODE, 0);
  endtask

  // dual mode halves wrap on their own; then the lower word lags by three clocks
  task t_dual;
    int          b;
    logic [23:0] ah, al;
    bus(1, `BAS_OFF_MODE, 32'h00000004);
    go(24'h000ffe, 24'h001001, 4, 0, 1, b);
    chk("dual", 24'h000ffe, u_mem.log_q[b]);
    chk("dual", 24'h001fff, u_mem.log_q[b + 1]);
    chk("dual", 24'h002000, u_mem.log_q[b + 2]);
    chk("dual", 24'h003001, u_mem.log_q[b + 3]);
    bus(1, `BAS_OFF_MODE, 32'h00000018);
    go(24'h000ffe, 24'h001001, 8, 0, 1, b);
    for (int k = 3; k < 8; k++)
    begin
      ah = 24'h000ffe + k * 24'h001001;
      al = 24'h000ffe + (k - 3) * 24'h001001;
      chk("lo delay", {ah[23:12], al[11:0]}, u_mem.log_q[b + k]);
    end
    bus(1, `BAS_OFF_MODE, 0);
  endtask

  task t_delay;
    int n0, n1;
    lat(n0);
    bus(1, `BAS_OFF_SDLY, 32'h00000025);
    lat(n1);
    chk("delay", 5, n1 - n0);
    bus(1, `BAS_OFF_SDLY, 0);
  endtask

  task t_xbar;
    bus(1, `BAS_OFF_XIDX, 0);
    bus(1, `BAS_OFF_XDATA, 32'h00000041);
    bus(1, `BAS_OFF_XDATA, 32'h00000042);
    bus(1, `BAS_OFF_XDATA, 32'h00000040);
    bus(1, `BAS_OFF_XDATA, 32'h00000058);
    xm[0] = 6'h01;
    xm[1] = 6'h02;
    xm[2] = 6'h00;
    xm[3] = 6'h18;
    run(24'h000008, 1, 8, 0, 1);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    {rstn, hsel, hwrite, start_in, htrans} = 0;
    {haddr, hwdata} = 0;
    hsize = 3'h2;
    mismatches = 0;
    samples_checked = 0;
    for (int k = 0; k < 24; k++)
      xm[k] = k[5:0];
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_modes;
    t_restart;
    run(24'hfffffe, 1, 3, 1, 2);
    t_delay;
    t_dual;
    t_xbar;
    report_and_stop;
  end
endmodule // bas_top_tb
